/* verilog/borrow_pkg.sv */
// Shared constants of the borrow-lookahead accumulator adder
package borrow_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int ACC_WIDTH = 48;
  localparam int AUX_WIDTH = 36;

  // ---------------------------------------------------------------
  // Lookahead structure
  // ---------------------------------------------------------------
  localparam int STAGES_PER_GROUP = 3;
  localparam int GROUPS_PER_SECTION = 4;
  localparam int STAGES_PER_SECTION = STAGES_PER_GROUP * GROUPS_PER_SECTION;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [ACC_WIDTH-1:0] ACC_RESET = 48'h0000_0000_0000;
  localparam logic [AUX_WIDTH-1:0] AUX_RESET = 36'h0_0000_0000;

endpackage

/* verilog/pyramid_if.sv */
// Carrier between the accumulator control and one borrow pyramid
`timescale 1ns/10ps

interface pyramid_if
  import borrow_pkg::*;
#(
  parameter int WIDTH = 48
);
  localparam int NG = WIDTH / STAGES_PER_GROUP;
  localparam int NS = WIDTH / STAGES_PER_SECTION;

  // Operands and mode
  logic [WIDTH-1:0] a;
  logic [WIDTH-1:0] x;
  logic partial_add;
  // Result mask
  logic [WIDTH-1:0] toggle;
  // Internal levels, exposed for observation
  logic [WIDTH-1:0] stage_borrow;
  logic [NG-1:0] grp_enable;
  logic [NG-1:0] grp_gen;
  logic [NS-1:0] sec_enable;
  logic [NS-1:0] sec_gen;
  logic [NS-1:0] sec_borrow;

  modport net (
    input a, x, partial_add,
    output toggle, stage_borrow, grp_enable, grp_gen, sec_enable, sec_gen, sec_borrow
  );
  modport ctl (
    output a, x, partial_add,
    input toggle, stage_borrow, grp_enable, grp_gen, sec_enable, sec_gen, sec_borrow
  );
endinterface

/* verilog/borrow_pyramid.sv */
// Combinational borrow-lookahead pyramid producing a per-bit toggle mask
`timescale 1ns/10ps

module borrow_pyramid
  import borrow_pkg::*;
#(
  parameter int WIDTH = 48
) (
  // Operand, mode and result
  pyramid_if.net bus
);
  localparam int NG = WIDTH / STAGES_PER_GROUP;
  localparam int NS = NG / GROUPS_PER_SECTION;

  logic [WIDTH-1:0] stage_en;
  logic [WIDTH-1:0] stage_gen;
  logic [WIDTH-1:0] bin;
  logic [NG-1:0] ge;
  logic [NG-1:0] gg;
  logic [NG-1:0] gbin;
  logic [NS-1:0] se;
  logic [NS-1:0] sg;
  logic [NS-1:0] sbin;

  // ---------------------------------------------------------------
  // Stage level
  // ---------------------------------------------------------------
  // Complement of x is subtracted, so 0/0 means 0 minus 1
  assign stage_en = bus.a ^ bus.x;
  assign stage_gen = ~bus.a & ~bus.x;

  // ---------------------------------------------------------------
  // Group level and stage borrow inputs
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NG; g++) begin : gen_group
      localparam int B = g * STAGES_PER_GROUP;
      // Whole group passes a borrow through
      assign ge[g] = &stage_en[B +: STAGES_PER_GROUP];
      // Borrow escapes the top of the group
      assign gg[g] = stage_gen[B+2] | (stage_gen[B+1] & stage_en[B+2]) |
                     (stage_gen[B] & stage_en[B+1] & stage_en[B+2]);
      // Group borrow input from lower groups or the section input
      if ((g % GROUPS_PER_SECTION) == 0) begin : gen_first
        assign gbin[g] = sbin[g / GROUPS_PER_SECTION];
      end else begin : gen_rest
        assign gbin[g] = gg[g-1] | (ge[g-1] & gbin[g-1]);
      end
      // Stage borrow inputs inside the group
      assign bin[B] = gbin[g];
      assign bin[B+1] = stage_gen[B] | (stage_en[B] & gbin[g]);
      assign bin[B+2] = stage_gen[B+1] | (stage_en[B+1] & stage_gen[B]) |
                        (stage_en[B+1] & stage_en[B] & gbin[g]);
    end
  endgenerate

  // ---------------------------------------------------------------
  // Section level with end-around borrow
  // ---------------------------------------------------------------
  genvar s;
  generate
    for (s = 0; s < NS; s++) begin : gen_section
      localparam int G = s * GROUPS_PER_SECTION;
      assign se[s] = &ge[G +: GROUPS_PER_SECTION];
      assign sg[s] = gg[G+3] | (ge[G+3] & gg[G+2]) | (ge[G+3] & ge[G+2] & gg[G+1]) |
                     (ge[G+3] & ge[G+2] & ge[G+1] & gg[G]);
      // Walk downward around the ring; the last term is this section's own borrow
      always_comb begin
        logic pass;
        logic b;
        int idx;
        pass = 1'b1;
        b = 1'b0;
        idx = 0;
        for (int k = 1; k <= NS; k++) begin
          idx = (s - k + NS) % NS;
          b = b | (pass & sg[idx]);
          pass = pass & se[idx];
        end
        sbin[s] = b;
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Toggle control
  // ---------------------------------------------------------------
  // Partial add forces every stage to look borrowed, so the mask is x
  assign bus.toggle = ~(bus.x ^ (bin | {WIDTH{bus.partial_add}}));
  assign bus.stage_borrow = bin;
  assign bus.grp_enable = ge;
  assign bus.grp_gen = gg;
  assign bus.sec_enable = se;
  assign bus.sec_gen = sg;
  assign bus.sec_borrow = sbin;

endmodule

/* verilog/accumulator_adder.sv */
// Accumulator and auxiliary register updated through borrow pyramids
//
// Operation
// - Add by subtracting the operand's complement
// - Differing bits mark stage borrow enable
// - Both zero generates; both one absorbs
// - Group enable when all three stages enable
// - Group generates per top-down stage cases
// - Enable and generate never both asserted
// - Section enable when all four groups enable
// - Section generates if group borrow escapes
// - Section borrow input wraps, cases exclusive
// - Section one borrow wraps end-around
// - Forty-eight bits, sixteen groups, four sections
// - Auxiliary register uses same structure, narrower
// - Toggle control inverts its accumulator bit
// - Group borrow input from lower groups
// - Stage borrow input from lower stages
// - Toggle when operand bit equals borrow
// - Partial add inverts where operand is one
`timescale 1ns/10ps

module accumulator_adder
  import borrow_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Accumulator control
  input wire logic acc_load,
  input wire logic [ACC_WIDTH-1:0] acc_load_value,
  input wire logic acc_add,
  input wire logic [ACC_WIDTH-1:0] operand,
  // Auxiliary register control
  input wire logic aux_load,
  input wire logic [AUX_WIDTH-1:0] aux_load_value,
  input wire logic aux_add,
  input wire logic [AUX_WIDTH-1:0] aux_operand,
  // Mode
  input wire logic partial_add,
  // Register contents
  output logic [ACC_WIDTH-1:0] acc,
  output logic [AUX_WIDTH-1:0] aux
);

  // ---------------------------------------------------------------
  // Pyramid instances
  // ---------------------------------------------------------------
  pyramid_if #(.WIDTH(ACC_WIDTH)) acc_bus ();
  pyramid_if #(.WIDTH(AUX_WIDTH)) aux_bus ();

  // Operands feed straight from the registers and the operand port
  assign acc_bus.a = acc;
  assign acc_bus.x = operand;
  assign acc_bus.partial_add = partial_add;
  assign aux_bus.a = aux;
  assign aux_bus.x = aux_operand;
  assign aux_bus.partial_add = partial_add;

  // Full-width network over all stages
  borrow_pyramid #(.WIDTH(ACC_WIDTH)) u_acc_pyramid (
    .bus(acc_bus.net)
  );

  // Same structure, only the width differs
  borrow_pyramid #(.WIDTH(AUX_WIDTH)) u_aux_pyramid (
    .bus(aux_bus.net)
  );

  // ---------------------------------------------------------------
  // Result capture
  // ---------------------------------------------------------------
  // Load wins over add; the network settles well inside one 5 ns period
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= ACC_RESET;
    end else if (acc_load) begin
      acc <= acc_load_value;
    end else if (acc_add) begin
      acc <= acc ^ acc_bus.toggle;
    end
  end

  // Auxiliary register follows the same discipline
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aux <= AUX_RESET;
    end else if (aux_load) begin
      aux <= aux_load_value;
    end else if (aux_add) begin
      aux <= aux ^ aux_bus.toggle;
    end
  end

  // ---------------------------------------------------------------
  // Reference arithmetic for the checks
  // ---------------------------------------------------------------
  logic [ACC_WIDTH:0] acc_diff;
  logic [ACC_WIDTH-1:0] acc_ref;
  logic [AUX_WIDTH:0] aux_diff;
  logic [AUX_WIDTH-1:0] aux_ref;

  // Subtract the complement, then repay an end-around borrow
  always_comb begin
    acc_diff = {1'b0, acc} - {1'b0, ~operand};
    acc_ref = acc_diff[ACC_WIDTH] ? (acc_diff[ACC_WIDTH-1:0] - ACC_WIDTH'(1)) : acc_diff[ACC_WIDTH-1:0];
    aux_diff = {1'b0, aux} - {1'b0, ~aux_operand};
    aux_ref = aux_diff[AUX_WIDTH] ? (aux_diff[AUX_WIDTH-1:0] - AUX_WIDTH'(1)) : aux_diff[AUX_WIDTH-1:0];
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Full add gives the ones' complement sum one edge later
  AST_ACC_SUM: assert property (
    (acc_add && !acc_load && !partial_add) |=> (acc == $past(acc_ref))
  ) else $error("accumulator sum mismatch");

  // Auxiliary register adds identically at its own width
  AST_AUX_SUM: assert property (
    (aux_add && !aux_load && !partial_add) |=> (aux == $past(aux_ref))
  ) else $error("auxiliary sum mismatch");

  // Partial add flips exactly the operand's one bits
  AST_PARTIAL: assert property (
    (acc_add && !acc_load && partial_add) |=> (acc == ($past(acc) ^ $past(operand)))
  ) else $error("partial add mismatch");

  // Without a strobe the accumulator holds
  AST_HOLD: assert property (
    (!acc_add && !acc_load) |=> $stable(acc)
  ) else $error("accumulator changed without strobe");

  // Groups never enable and generate at once
  AST_GRP_EXCL: assert property (
    ((acc_bus.grp_enable & acc_bus.grp_gen) == '0) && ((aux_bus.grp_enable & aux_bus.grp_gen) == '0)
  ) else $error("group enable and generate together");

  // Sections never enable and generate at once
  AST_SEC_EXCL: assert property (
    ((acc_bus.sec_enable & acc_bus.sec_gen) == '0) && ((aux_bus.sec_enable & aux_bus.sec_gen) == '0)
  ) else $error("section enable and generate together");

  // Differing bits at every stage mean nothing generates and nothing borrows
  AST_ALL_ENABLE: assert property (
    ((acc ^ operand) == '1) |-> ((acc_bus.sec_gen == '0) && (acc_bus.sec_borrow == '0))
  ) else $error("propagate chain produced a borrow");

  // Both operands zero: every stage borrows and the register keeps its value
  AST_ALL_GEN: assert property (
    (acc_add && !acc_load && !partial_add && acc == '0 && operand == '0) |=> (acc == '0)
  ) else $error("zero plus zero changed accumulator");

  // Stage borrows and toggle mask against the plain subtraction, not the network's own terms
  AST_TOGGLE: assert property (
    !partial_add |-> ((acc_bus.stage_borrow == (acc_ref ^ acc ^ ~operand)) &&
                      (acc_bus.toggle == (acc_ref ^ acc)) &&
                      (aux_bus.stage_borrow == (aux_ref ^ aux ^ ~aux_operand)))
  ) else $error("toggle mask mismatch");

  // Auxiliary partial add flips exactly the operand's one bits
  AST_AUX_PARTIAL: assert property (
    (aux_add && !aux_load && partial_add) |=> (aux == ($past(aux) ^ $past(aux_operand)))
  ) else $error("auxiliary partial add mismatch");

  // Without a strobe the auxiliary register holds
  AST_AUX_HOLD: assert property (
    (!aux_add && !aux_load) |=> $stable(aux)
  ) else $error("auxiliary register changed without strobe");

  // Auxiliary ring has three sections; its lowest one wraps onto itself
  AST_AUX_WRAP: assert property (
    (aux_bus.sec_gen == 3'h1 && aux_bus.sec_enable == 3'h6) |-> (aux_bus.sec_borrow == 3'h7)
  ) else $error("auxiliary end-around borrow lost");

  // A load takes the given value even when an add is strobed with it
  AST_LOAD_WINS: assert property (
    acc_load |=> (acc == $past(acc_load_value))
  ) else $error("accumulator load lost");

  // A section generating its own wrapped borrow needs all others propagating
  AST_WRAP: assert property (
    (acc_bus.sec_gen == 4'h1 && acc_bus.sec_enable == 4'he) |-> (acc_bus.sec_borrow == 4'hf)
  ) else $error("end-around borrow lost");

  // Main scenarios
  COV_ADD: cover property (acc_add && !acc_load && !partial_add);
  COV_PARTIAL: cover property (acc_add && !acc_load && partial_add);
  COV_END_AROUND: cover property (acc_add && !partial_add && acc_bus.sec_borrow[0]);
  COV_AUX_ADD: cover property (aux_add && !aux_load && !partial_add);
  COV_WRAP_ALL: cover property (acc_add && acc_bus.sec_gen == 4'h1 && acc_bus.sec_enable == 4'he);

endmodule

/* dv/arith_ctl.sv */
// Arithmetic control sequencer model driving both register strobes
`timescale 1ns/10ps

module arith_ctl
  import borrow_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Accumulator strobes
  output logic acc_load,
  output logic [ACC_WIDTH-1:0] acc_load_value,
  output logic acc_add,
  output logic [ACC_WIDTH-1:0] operand,
  // Auxiliary strobes
  output logic aux_load,
  output logic [AUX_WIDTH-1:0] aux_load_value,
  output logic aux_add,
  output logic [AUX_WIDTH-1:0] aux_operand,
  // Mode
  output logic partial_add
);
  // ---------------------------------------------------------------
  // Idle levels at time zero
  // ---------------------------------------------------------------
  initial begin
    {acc_load, acc_add, aux_load, aux_add, partial_add} = 5'h00;
    {acc_load_value, operand} = {2{48'h0000_0000_0000}};
    {aux_load_value, aux_operand} = {2{36'h0_0000_0000}};
  end

  // ---------------------------------------------------------------
  // Strobe tasks
  // ---------------------------------------------------------------
  // One strobe cycle on both registers; launched off the falling edge
  task automatic strobe(input bit ld, input bit ad, input logic [ACC_WIDTH-1:0] v,
                        input logic [ACC_WIDTH-1:0] x, input bit pa);
    @(negedge core_clk);
    partial_add = pa;
    {acc_load, aux_load} = {2{ld}};
    {acc_add, aux_add} = {2{ad}};
    acc_load_value = v;
    operand = x;
    aux_load_value = v[AUX_WIDTH-1:0];
    aux_operand = x[AUX_WIDTH-1:0];
  endtask

  // Released lines are scrambled so stale data never passes for live data
  task automatic idle();
    @(negedge core_clk);
    {acc_load, acc_add, aux_load, aux_add, partial_add} = 5'h00;
    {acc_load_value, operand} = ~{acc_load_value, operand};
    {aux_load_value, aux_operand} = ~{aux_load_value, aux_operand};
  endtask
endmodule

/* dv/borrow_lookahead_subtractor_tb.sv */
// Self-checking bench for the accumulator and auxiliary borrow adders
`timescale 1ns/10ps

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module borrow_lookahead_subtractor_tb
  import borrow_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic core_clk;
  logic rst_n;
  logic acc_load, acc_add, aux_load, aux_add, partial_add;
  logic [ACC_WIDTH-1:0] acc_load_value, operand, acc;
  logic [AUX_WIDTH-1:0] aux_load_value, aux_operand, aux;
  int n_errors = 0;
  int num_checks = 0;
  // Operand table: sample sum, end-around, +0, -0, zero, section crossing, lowest section wrapping onto itself
  localparam logic [ACC_WIDTH-1:0] TA [7] = '{48'h0007_b0f8_2d4f, 48'h8000_0000_0000, 48'h1234_5678_9abc,
    48'hffff_ffff_ffff, 48'h0000_0000_0000, 48'h0000_0000_0fff, 48'h0000_0000_0000};
  localparam logic [ACC_WIDTH-1:0] TX [7] = '{48'h0002_87f3_dd8b, 48'h8000_0000_0001, 48'hedcb_a987_6543,
    48'hffff_ffff_ffff, 48'h0000_0000_0000, 48'h0000_0000_0001, 48'hffff_ffff_f000};

  // ---------------------------------------------------------------
  // Clock, partner and design
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  arith_ctl ctl_u (.core_clk(core_clk), .acc_load(acc_load), .acc_load_value(acc_load_value),
    .acc_add(acc_add), .operand(operand), .aux_load(aux_load), .aux_load_value(aux_load_value),
    .aux_add(aux_add), .aux_operand(aux_operand), .partial_add(partial_add));

  accumulator_adder dut_u (.core_clk(core_clk), .rst_n(rst_n), .acc_load(acc_load),
    .acc_load_value(acc_load_value), .acc_add(acc_add), .operand(operand), .aux_load(aux_load),
    .aux_load_value(aux_load_value), .aux_add(aux_add), .aux_operand(aux_operand),
    .partial_add(partial_add), .acc(acc), .aux(aux));

  // ---------------------------------------------------------------
  // Reference and scenarios
  // ---------------------------------------------------------------
  // Plain add; a carry out of the top or an all-ones sum is taken back end-around
  function automatic logic [ACC_WIDTH-1:0] oc_add(input logic [ACC_WIDTH-1:0] a,
                                                  input logic [ACC_WIDTH-1:0] x, input int w);
    logic [ACC_WIDTH:0] mask;
    logic [ACC_WIDTH:0] sum;
    mask = (49'h1 << w) - 49'h1;
    sum = {1'b0, a} + {1'b0, x};
    if (sum >= mask) sum = (sum + 49'h1) & mask;
    return sum[ACC_WIDTH-1:0];
  endfunction

  task automatic t_reset_values();
    `CHK(acc, ACC_RESET)
    `CHK(aux, AUX_RESET)
  endtask

  task automatic t_add_table();
    logic [ACC_WIDTH-1:0] sa;
    logic [ACC_WIDTH-1:0] sx;
    ctl_u.strobe(1'b1, 1'b0, TA[0], TX[0], 1'b0);
    ctl_u.strobe(1'b0, 1'b1, TA[0], TX[0], 1'b0);
    ctl_u.idle();
    `CHK(acc, 48'h000a_38ec_0ada)
    for (int i = 0; i < 7; i++) begin
      sa = {12'h000, TA[i][AUX_WIDTH-1:0]};
      sx = {12'h000, TX[i][AUX_WIDTH-1:0]};
      ctl_u.strobe(1'b1, 1'b0, TA[i], TX[i], 1'b0);
      ctl_u.strobe(1'b0, 1'b1, TA[i], TX[i], 1'b0);
      ctl_u.idle();
      `CHK(acc, oc_add(TA[i], TX[i], ACC_WIDTH))
      `CHK(aux, oc_add(sa, sx, AUX_WIDTH) & 36'hf_ffff_ffff)
    end
  endtask

  task automatic t_partial();
    ctl_u.strobe(1'b1, 1'b0, TA[2], TX[0], 1'b0);
    ctl_u.strobe(1'b0, 1'b1, TA[2], TX[0], 1'b1);
    ctl_u.idle();
    `CHK(acc, TA[2] ^ TX[0])
    `CHK(aux, TA[2][AUX_WIDTH-1:0] ^ TX[0][AUX_WIDTH-1:0])
  endtask

  task automatic t_back_to_back();
    ctl_u.strobe(1'b1, 1'b0, TA[5], TX[1], 1'b0);
    ctl_u.strobe(1'b0, 1'b1, TA[5], TX[1], 1'b0);
    ctl_u.strobe(1'b0, 1'b1, TA[5], TX[3], 1'b0);
    ctl_u.idle();
    `CHK(acc, oc_add(oc_add(TA[5], TX[1], ACC_WIDTH), TX[3], ACC_WIDTH))
    // Load and add together: the load wins
    ctl_u.strobe(1'b1, 1'b1, TA[1], TX[1], 1'b0);
    ctl_u.idle();
    `CHK(acc, TA[1])
  endtask

  task automatic t_hold_and_reset();
    repeat (3) @(negedge core_clk);
    `CHK(acc, TA[1])
    rst_n = 1'b0;
    #1;
    `CHK(acc, ACC_RESET)
    `CHK(aux, AUX_RESET)
    @(negedge core_clk);
    rst_n = 1'b1;
  endtask

  task automatic summarize();
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    t_reset_values();
    t_add_table();
    t_partial();
    t_back_to_back();
    t_hold_and_reset();
    t_add_table();
    summarize();
  end

  // A hang counts as a mismatch
  initial begin
    #200000;
    n_errors++;
    summarize();
  end
endmodule
